// ---- rtl/iop_chan_pkg.sv ----
// Constants, states and carriers for the processor channel block.
// Assumes a single 200 MHz system clock; no interface or bus of its own.
package iop_chan_pkg;

    localparam int PW    = 16;
    localparam int NGRP  = 4;
    localparam int NPIN  = 7;
    localparam int MEM_W = PW * 4;

    // Synchronised pin positions
    localparam int PIN_RDY  = 0;
    localparam int PIN_DISC = 1;
    localparam int PIN_RES  = 2;
    localparam int PIN_MNT  = 3;

    // Channel function codes
    localparam logic [3:0] FN_CLEAR   = 4'h0;
    localparam logic [3:0] FN_START   = 4'h1;
    localparam logic [3:0] FN_COUNT   = 4'h2;
    localparam logic [3:0] FN_CLR_ERR = 4'h3;
    localparam logic [3:0] FN_CTRL    = 4'h4;
    localparam logic [3:0] FN_IE_OFF  = 4'h6;
    localparam logic [3:0] FN_IE_ON   = 4'h7;
    localparam logic [3:0] FN_RD_ADDR = 4'h8;
    localparam logic [3:0] FN_RD_STAT = 4'h9;

    localparam logic [PW-1:0] ALIGN_MASK = 16'hFFFC;
    localparam logic [PW-1:0] BURST_STEP = 16'h0004;
    localparam logic [PW-1:0] CNT_ONE    = 16'h0001;
    localparam logic [2:0]    FILL_ONE   = 3'h1;
    localparam logic [2:0]    FILL_LAST  = 3'h3;
    localparam int            STAT_FLAG  = 15;
    localparam int            CTRL_LO    = 8;
    localparam int            EXT_WDISC  = 0;
    localparam int            EXT_HOLD   = 1;

    typedef enum logic [2:0] {
        IS_IDLE  = 3'b001,
        IS_RECV  = 3'b010,
        IS_STORE = 3'b100
    } ist_t;

    typedef enum logic [3:0] {
        OS_IDLE  = 4'b0001,
        OS_FETCH = 4'b0010,
        OS_SEND  = 4'b0100,
        OS_WAIT  = 4'b1000
    } ost_t;

    typedef struct packed {
        logic          valid;
        logic          sel;
        logic [3:0]    code;
        logic [PW-1:0] acc;
    } func_req_t;

    typedef struct packed {
        logic             req;
        logic             we;
        logic [PW-1:0]    addr;
        logic [MEM_W-1:0] wdata;
    } mem_cmd_t;

    typedef struct packed {
        logic [NPIN-1:0] sy1;
        logic [NPIN-1:0] sy2;
        logic [NPIN-1:0] sy3;
        logic [NPIN-1:0] lvl;
        ist_t            ist;
        ost_t            ost;
        logic            in_busy;
        logic            in_done;
        logic            in_ie;
        logic            rdy_wait;
        logic            in_last;
        logic [NGRP-1:0] perr;
        logic [PW-1:0]   in_addr;
        logic [PW-1:0]   in_cnt;
        logic [2:0]      in_fill;
        logic            out_busy;
        logic            out_done;
        logic            out_ie;
        logic            seq_err;
        logic [PW-1:0]   out_addr;
        logic [PW-1:0]   out_cnt;
        logic [2:0]      out_sent;
        logic [7:0]      ext;
        logic            co_rdy;
        logic            co_disc;
        logic [PW-1:0]   co_data;
        logic [NGRP-1:0] co_par;
        logic [PW-1:0]   rdata;
        logic            rvalid;
    } state_t;

    localparam state_t ST_RESET = '{ist: IS_IDLE, ost: OS_IDLE, default: '0};

endpackage

// ---- rtl/parcel_buf.sv ----
// Four-parcel burst store with registered read data.
// Assumes write and whole-word load never collide in one cycle.
`timescale 1ns/100ps
module parcel_buf #(
    parameter int PW = 16,
    parameter int N  = 4
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 en,
    input  wire logic                 wr,
    input  wire logic [$clog2(N)-1:0] widx,
    input  wire logic [PW-1:0]        wdata,
    input  wire logic                 ld,
    input  wire logic [N*PW-1:0]      ldata,
    output logic      [N*PW-1:0]      q
);
    logic [N-1:0][PW-1:0] mem_r;
    logic [N-1:0][PW-1:0] mem_nxt;

    always_comb
    begin
        mem_nxt = mem_r;
        if (ld)
            mem_nxt = ldata;
        if (wr)
            mem_nxt[widx] = wdata;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            mem_r <= '0;
        else if (en)
            mem_r <= mem_nxt;
    end

    assign q = mem_r;
endmodule

// ---- rtl/iop_cpu_channel_dma.sv ----
// Block-mode input and output channel halves between I/O memory and
// the central processor channel. Pins from the processor are asynchronous;
// the memory port and function port sit on CLK_SYS.
`timescale 1ns/100ps
module iop_cpu_channel_dma
    import iop_chan_pkg::*;
(
    input  wire logic               CLK_SYS,
    input  wire logic               RESET,
    input  wire logic               CLK_EN,
    input  wire func_req_t          FUNC_REQ,
    output logic      [PW-1:0]      FUNC_RDATA,
    output logic                    FUNC_RVALID,
    output logic                    IN_BUSY,
    output logic                    IN_DONE,
    output logic                    IN_IRQ,
    output logic                    OUT_BUSY,
    output logic                    OUT_DONE,
    output logic                    OUT_IRQ,
    output mem_cmd_t                MEM_CMD,
    input  wire logic               MEM_ACK,
    input  wire logic [MEM_W-1:0]   MEM_RDATA,
    input  wire logic [PW-1:0]      CI_DATA,
    input  wire logic [NGRP-1:0]    CI_PARITY,
    input  wire logic               CI_READY,
    input  wire logic               CI_DISC,
    output logic      [PW-1:0]      CO_DATA,
    output logic      [NGRP-1:0]    CO_PARITY,
    output logic                    CO_READY,
    output logic                    CO_DISC,
    input  wire logic               CO_RESUME,
    input  wire logic [NGRP-1:0]    MAINT_DATA,
    output logic      [7:0]         CO_CTRL
);
    state_t            s;
    state_t            nxt;
    logic [NPIN-1:0]   pins;
    logic [NPIN-1:0]   rise;
    logic [NPIN-1:0]   lvl_nxt;
    logic [NGRP-1:0]   bad;
    logic [NGRP-1:0]   send_par;
    logic [PW-1:0]     send_p;
    logic [MEM_W-1:0]  ibuf_q;
    logic [MEM_W-1:0]  obuf_q;
    logic              in_fn;
    logic              out_fn;
    logic              mem_in;
    logic              take;
    logic              rdy_set;
    logic              seq_set;
    logic              out_ld;

    assign pins = {MAINT_DATA, CO_RESUME, CI_DISC, CI_READY};
    assign send_p = obuf_q[s.out_sent[1:0]*PW +: PW];

    // Change counts once second and third stage agree
    for (genvar i = 0; i < NPIN; i++)
    begin : g_pin
        assign lvl_nxt[i] = (s.sy2[i] == s.sy3[i]) ? s.sy3[i] : s.lvl[i];
        assign rise[i]    = s.sy2[i] & s.sy3[i] & ~s.lvl[i];
    end

    // Odd parity per nibble, in and out
    for (genvar g = 0; g < NGRP; g++)
    begin : g_par
        assign bad[g]      = ~^{CI_DATA[g*4 +: 4], CI_PARITY[g]};
        assign send_par[g] = ~^send_p[g*4 +: 4];
    end

    parcel_buf #(
        .PW (PW),
        .N  (4)
    ) u_ibuf (
        .clk   (CLK_SYS),
        .rst   (RESET),
        .en    (CLK_EN),
        .wr    (take),
        .widx  (s.in_fill[1:0]),
        .wdata (CI_DATA),
        .ld    (1'b0),
        .ldata ('0),
        .q     (ibuf_q)
    );

    parcel_buf #(
        .PW (PW),
        .N  (4)
    ) u_obuf (
        .clk   (CLK_SYS),
        .rst   (RESET),
        .en    (CLK_EN),
        .wr    (1'b0),
        .widx  (2'h0),
        .wdata ('0),
        .ld    (out_ld),
        .ldata (MEM_RDATA),
        .q     (obuf_q)
    );

    always_comb
    begin
        nxt      = s;
        in_fn    = FUNC_REQ.valid & ~FUNC_REQ.sel;
        out_fn   = FUNC_REQ.valid & FUNC_REQ.sel;
        mem_in   = (s.ist == IS_STORE);
        take     = 1'b0;
        rdy_set  = 1'b0;
        seq_set  = 1'b0;
        out_ld   = 1'b0;
        nxt.sy1  = pins;
        nxt.sy2  = s.sy1;
        nxt.sy3  = s.sy2;
        nxt.lvl  = lvl_nxt;
        nxt.co_rdy  = 1'b0;
        nxt.co_disc = 1'b0;
        nxt.rvalid  = 1'b0;

        // Input half
        case (s.ist)
            IS_IDLE:
            begin
                rdy_set = rise[PIN_RDY];
            end
            IS_RECV:
            begin
                if (rise[PIN_DISC] || s.in_cnt == '0)
                begin
                    if (s.in_fill == '0)
                    begin
                        nxt.ist     = IS_IDLE;
                        nxt.in_busy = 1'b0;
                        nxt.in_done = 1'b1;
                    end
                    else
                    begin
                        nxt.ist     = IS_STORE;
                        nxt.in_last = 1'b1;
                    end
                end
                else if (rise[PIN_RDY] || s.rdy_wait)
                begin
                    take = 1'b1;
                end
            end
            IS_STORE:
            begin
                rdy_set = rise[PIN_RDY];
                if (MEM_ACK)
                begin
                    nxt.in_fill = '0;
                    if (s.in_last)
                    begin
                        nxt.in_addr = s.in_addr + {{(PW-3){1'b0}}, s.in_fill};
                        nxt.ist     = IS_IDLE;
                        nxt.in_busy = 1'b0;
                        nxt.in_done = 1'b1;
                    end
                    else
                    begin
                        nxt.in_addr = s.in_addr + BURST_STEP;
                        nxt.ist     = IS_RECV;
                    end
                end
            end
            default:
            begin
                nxt.ist = IS_IDLE;
            end
        endcase

        if (rdy_set)
            nxt.rdy_wait = 1'b1;
        if (take)
        begin
            nxt.rdy_wait = 1'b0;
            nxt.in_fill  = s.in_fill + FILL_ONE;
            nxt.in_cnt   = s.in_cnt - CNT_ONE;
            nxt.perr     = s.perr | bad;
            if (s.in_cnt == CNT_ONE || s.in_fill == FILL_LAST)
            begin
                nxt.ist     = IS_STORE;
                nxt.in_last = (s.in_cnt == CNT_ONE);
            end
        end

        if (in_fn)
        begin
            case (FUNC_REQ.code)
                FN_CLEAR:
                begin
                    nxt.ist     = IS_IDLE;
                    nxt.in_busy = 1'b0;
                    nxt.in_done = 1'b0;
                    nxt.in_fill = '0;
                    nxt.in_last = 1'b0;
                end
                FN_START:
                begin
                    nxt.in_addr = FUNC_REQ.acc & ALIGN_MASK;
                    nxt.ist     = IS_RECV;
                    nxt.in_busy = 1'b1;
                    nxt.in_done = 1'b0;
                    nxt.in_fill = '0;
                    nxt.in_last = 1'b0;
                end
                FN_COUNT:
                begin
                    nxt.in_cnt = FUNC_REQ.acc;
                end
                FN_CLR_ERR:
                begin
                    nxt.perr = take ? bad : '0;
                end
                FN_CTRL:
                begin
                    nxt.rdy_wait = rdy_set;
                end
                FN_IE_OFF:
                begin
                    nxt.in_ie = 1'b0;
                end
                FN_IE_ON:
                begin
                    nxt.in_ie = 1'b1;
                end
                FN_RD_ADDR:
                begin
                    nxt.rdata  = s.in_addr;
                    nxt.rvalid = 1'b1;
                end
                FN_RD_STAT:
                begin
                    nxt.rdata            = '0;
                    nxt.rdata[NGRP-1:0]  = s.perr;
                    nxt.rdata[STAT_FLAG] = s.rdy_wait;
                    nxt.rvalid           = 1'b1;
                end
                default:
                begin
                end
            endcase
        end

        // Output half
        seq_set = rise[PIN_RES] && (s.ost == OS_IDLE || s.ost == OS_FETCH);
        case (s.ost)
            OS_IDLE:
            begin
            end
            OS_FETCH:
            begin
                if (s.out_cnt == '0)
                begin
                    nxt.ost      = OS_IDLE;
                    nxt.out_busy = 1'b0;
                    nxt.out_done = 1'b1;
                    nxt.co_disc  = ~s.ext[EXT_HOLD];
                end
                else if (MEM_ACK && !mem_in)
                begin
                    out_ld  = 1'b1;
                    nxt.ost = OS_SEND;
                end
            end
            OS_SEND:
            begin
                nxt.co_data = send_p;
                nxt.co_par  = send_par;
                nxt.co_rdy  = 1'b1;
                nxt.ost     = OS_WAIT;
            end
            OS_WAIT:
            begin
                if (rise[PIN_RES])
                begin
                    nxt.out_sent = s.out_sent + FILL_ONE;
                    nxt.out_cnt  = s.out_cnt - CNT_ONE;
                    if (s.out_cnt == CNT_ONE)
                    begin
                        nxt.out_addr = s.out_addr + {{(PW-3){1'b0}}, nxt.out_sent};
                        nxt.out_sent = '0;
                        nxt.ost      = OS_IDLE;
                        nxt.out_busy = 1'b0;
                        nxt.out_done = 1'b1;
                        nxt.co_disc  = ~s.ext[EXT_HOLD];
                    end
                    else if (s.out_sent == FILL_LAST)
                    begin
                        nxt.out_addr = s.out_addr + BURST_STEP;
                        nxt.out_sent = '0;
                        nxt.ost      = OS_FETCH;
                    end
                    else
                    begin
                        nxt.ost = OS_SEND;
                    end
                end
            end
            default:
            begin
                nxt.ost = OS_IDLE;
            end
        endcase

        if (seq_set)
            nxt.seq_err = 1'b1;

        if (out_fn)
        begin
            case (FUNC_REQ.code)
                FN_CLEAR:
                begin
                    nxt.ost      = OS_IDLE;
                    nxt.out_busy = 1'b0;
                    nxt.out_done = 1'b0;
                    nxt.out_sent = '0;
                    nxt.co_disc  = 1'b0;
                end
                FN_START:
                begin
                    nxt.out_addr = FUNC_REQ.acc & ALIGN_MASK;
                    nxt.ost      = OS_FETCH;
                    nxt.out_busy = 1'b1;
                    nxt.out_done = 1'b0;
                    nxt.out_sent = '0;
                end
                FN_COUNT:
                begin
                    nxt.out_cnt = FUNC_REQ.acc;
                end
                FN_CLR_ERR:
                begin
                    nxt.seq_err = seq_set;
                end
                FN_CTRL:
                begin
                    nxt.ext = FUNC_REQ.acc[PW-1:CTRL_LO];
                    if (FUNC_REQ.acc[CTRL_LO + EXT_WDISC])
                        nxt.co_disc = 1'b1;
                end
                FN_IE_OFF:
                begin
                    nxt.out_ie = 1'b0;
                end
                FN_IE_ON:
                begin
                    nxt.out_ie = 1'b1;
                end
                FN_RD_ADDR:
                begin
                    nxt.rdata  = s.out_addr;
                    nxt.rvalid = 1'b1;
                end
                FN_RD_STAT:
                begin
                    nxt.rdata            = '0;
                    nxt.rdata[NGRP-1:0]  = s.lvl[PIN_MNT +: NGRP];
                    nxt.rdata[STAT_FLAG] = s.seq_err;
                    nxt.rvalid           = 1'b1;
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
            s <= ST_RESET;
        else if (CLK_EN)
            s <= nxt;
    end

    assign FUNC_RDATA  = s.rdata;
    assign FUNC_RVALID = s.rvalid;
    assign IN_BUSY     = s.in_busy;
    assign IN_DONE     = s.in_done;
    assign IN_IRQ      = s.in_ie & s.in_done;
    assign OUT_BUSY    = s.out_busy;
    assign OUT_DONE    = s.out_done;
    assign OUT_IRQ     = s.out_ie & (s.out_done | s.seq_err);
    assign MEM_CMD.req   = mem_in | (s.ost == OS_FETCH);
    assign MEM_CMD.we    = mem_in;
    assign MEM_CMD.addr  = mem_in ? s.in_addr : s.out_addr;
    assign MEM_CMD.wdata = ibuf_q;
    assign CO_DATA     = s.co_data;
    assign CO_PARITY   = s.co_par;
    assign CO_READY    = s.co_rdy;
    assign CO_DISC     = s.co_disc;
    assign CO_CTRL     = s.ext;

    default clocking cb @(posedge CLK_SYS iff CLK_EN);
    endclocking
    default disable iff (RESET);

    a_in_cnt_load: assert property (in_fn && FUNC_REQ.code == FN_COUNT
        |=> s.in_cnt == $past(FUNC_REQ.acc) && $stable(s.in_busy))
        else $error("input count not loaded");
    a_perr_set: assert property (take && bad != '0 && !in_fn
        |=> (s.perr & $past(bad)) == $past(bad))
        else $error("parity flag missed");
    a_perr_clear: assert property (in_fn && FUNC_REQ.code == FN_CLR_ERR && !take
        |=> s.perr == '0 && $stable(s.in_done))
        else $error("parity flags not cleared");
    a_rdy_wait_set: assert property (rise[PIN_RDY] && s.ist == IS_IDLE
        |=> s.rdy_wait)
        else $error("ready waiting not set");
    a_in_irq_off: assert property (in_fn && FUNC_REQ.code == FN_IE_OFF
        |=> !IN_IRQ)
        else $error("input interrupt still raised");
    a_in_irq_done: assert property (s.ist == IS_STORE && MEM_ACK && s.in_last
        && s.in_ie && !in_fn |=> IN_IRQ)
        else $error("input done did not interrupt");
    a_in_status: assert property (in_fn && FUNC_REQ.code == FN_RD_STAT
        |=> FUNC_RVALID && FUNC_RDATA[STAT_FLAG] == $past(s.rdy_wait)
            && FUNC_RDATA[NGRP-1:0] == $past(s.perr))
        else $error("input status wrong");
    a_out_start: assert property (out_fn && FUNC_REQ.code == FN_START
        |=> OUT_BUSY && !OUT_DONE && s.out_addr == ($past(FUNC_REQ.acc) & ALIGN_MASK))
        else $error("output start wrong");
    a_out_clear: assert property (out_fn && FUNC_REQ.code == FN_CLEAR
        |=> !OUT_BUSY && !OUT_DONE ##1 !OUT_BUSY)
        else $error("output clear failed");
    a_out_done: assert property (s.ost == OS_WAIT && rise[PIN_RES]
        && s.out_cnt == CNT_ONE && !out_fn |=> OUT_DONE && !OUT_BUSY)
        else $error("output did not finish");
    a_seq_err: assert property (seq_set |=> s.seq_err)
        else $error("sequence error not flagged");
    a_hold_disc: assert property ($rose(s.out_done) && s.ext[EXT_HOLD]
        && !$past(out_fn) |-> !CO_DISC)
        else $error("disconnect sent while held");
    a_out_irq_err: assert property (seq_set && s.out_ie && !out_fn |=> OUT_IRQ)
        else $error("sequence error did not interrupt");

    c_in_done: cover property ($rose(s.in_done));
    c_out_done: cover property ($rose(s.out_done));
    c_pending_start: cover property (s.ist == IS_RECV && s.rdy_wait);
    c_seq_err: cover property ($rose(s.seq_err));
endmodule

// ---- bench/cpu_chan_model.sv ----
// Processor channel partner and I/O memory for the channel bench.
// Assumes the bench clock; all outputs change just after rising edges.
`timescale 1ns/100ps
module cpu_chan_model
    import iop_chan_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             slow,
    input  wire logic             kick,
    input  wire logic             co_ready,
    input  wire mem_cmd_t         mem_cmd,
    output logic                  co_resume,
    output logic                  mem_ack,
    output logic      [MEM_W-1:0] mem_rdata
);
    int wait_n = 0;
    initial
    begin
        co_resume = 1'b0;
        mem_ack   = 1'b0;
        mem_rdata = '0;
    end
    // Memory: one-cycle ack, parcel k holds its own address
    always @(posedge clk)
    begin
        mem_ack <= mem_cmd.req && !mem_ack;
        if (mem_cmd.req && !mem_ack)
            mem_rdata <= {mem_cmd.addr + 16'h0003, mem_cmd.addr + 16'h0002,
                          mem_cmd.addr + 16'h0001, mem_cmd.addr};
        else
            mem_rdata <= ~mem_rdata;
    end
    // Resume two cycles wide, prompt or slow; kick forces a stray one
    always @(posedge clk)
    begin
        if (co_ready)
            wait_n <= slow ? 10 : 3;
        else if (wait_n > 0)
            wait_n <= wait_n - 1;
        co_resume <= kick || (wait_n inside {1, 2});
    end
endmodule

// ---- bench/iop_cpu_channel_dma_bench.sv ----
// Self-checking bench for the processor channel block.
// Assumes the partner model answers memory and resume; pins driven here.
`timescale 1ns/100ps
module iop_cpu_channel_dma_bench
    import iop_chan_pkg::*;
;
    logic             clk = 0, rst = 1, ci_ready = 0, ci_disc = 0, slow = 0, kick = 0;
    func_req_t        req = '0;
    logic [PW-1:0]    rdata, co_data, ci_data = '0;
    logic [NGRP-1:0]  co_par, ci_par = '0, maint = 4'hA;
    logic             rvalid, in_busy, in_done, in_irq, out_busy, out_done, out_irq;
    logic             mem_ack, co_ready, co_disc, co_resume;
    logic [7:0]       co_ctrl;
    mem_cmd_t         mem_cmd;
    logic [MEM_W-1:0] mem_rdata, wd_seen;
    logic [PW-1:0]    a_seen;
    int               n_errors = 0, compares = 0, cycles = 0;

    iop_cpu_channel_dma i_dut (.CLK_SYS(clk), .RESET(rst), .CLK_EN(1'b1), .FUNC_REQ(req),
        .FUNC_RDATA(rdata), .FUNC_RVALID(rvalid), .IN_BUSY(in_busy), .IN_DONE(in_done),
        .IN_IRQ(in_irq), .OUT_BUSY(out_busy), .OUT_DONE(out_done), .OUT_IRQ(out_irq),
        .MEM_CMD(mem_cmd), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .CI_DATA(ci_data),
        .CI_PARITY(ci_par), .CI_READY(ci_ready), .CI_DISC(ci_disc), .CO_DATA(co_data),
        .CO_PARITY(co_par), .CO_READY(co_ready), .CO_DISC(co_disc), .CO_RESUME(co_resume),
        .MAINT_DATA(maint), .CO_CTRL(co_ctrl));
    cpu_chan_model i_cpu (.clk(clk), .slow(slow), .kick(kick), .co_ready(co_ready),
        .mem_cmd(mem_cmd), .co_resume(co_resume), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    always #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (mem_cmd.req && mem_cmd.we)
        begin
            wd_seen <= mem_cmd.wdata;
            a_seen  <= mem_cmd.addr;
        end
        if (cycles == 20000)
        begin
            n_errors++;
            summarize();
        end
    end

    function automatic logic [3:0] par(input logic [15:0] d);
        for (int g = 0; g < 4; g++)
            par[g] = ~^d[4*g +: 4];
    endfunction
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic fn(input logic s, input logic [3:0] c, input logic [15:0] a);
        @(negedge clk) req = '{valid: 1'b1, sel: s, code: c, acc: a};
        @(negedge clk) req.valid = 1'b0;
    endtask
    task automatic rd(input logic s, input logic [3:0] c, input logic [15:0] e, input string nm);
        fn(s, c, 16'h0000);
        chk("read valid", 1, rvalid);
        chk(nm, e, rdata);
    endtask
    task automatic send(input logic [15:0] d, input logic [3:0] p, input logic dsc);
        @(negedge clk) ci_data = d;
        ci_par = p;
        cyc(1);
        if (dsc) ci_disc = 1'b1;
        else ci_ready = 1'b1;
        cyc(2);
        ci_ready = 1'b0;
        ci_disc  = 1'b0;
        cyc(6);
        ci_data = ~d;
    endtask
    task automatic wait_in();
        for (int i = 0; i < 400 && in_done !== 1'b1; i++) @(negedge clk);
    endtask
    task automatic out_xfer(input logic [15:0] cnt, input logic [15:0] ad, input int ndisc);
        int n = 0, d = 0;
        fn(1, FN_COUNT, cnt);
        fn(1, FN_START, ad);
        chk("out busy", 1, out_busy);
        for (int i = 0; i < 900 && out_done !== 1'b1; i++)
        begin
            @(negedge clk);
            if (co_ready === 1'b1)
            begin
                chk("out data", (ad & ALIGN_MASK) + n, co_data);
                chk("out parity", par(co_data), co_par);
                n++;
            end
            d += (co_disc === 1'b1);
        end
        repeat (3) @(negedge clk) d += (co_disc === 1'b1);
        chk("parcels sent", cnt, n);
        chk("end busy", 0, out_busy);
        chk("end disconnects", ndisc, d);
        rd(1, FN_RD_ADDR, (ad & ALIGN_MASK) + cnt, "out address");
        chk("done kept", 1, out_done);
    endtask

    task automatic t_out();
        int d = 0;
        fn(1, FN_IE_ON, 16'h0000);
        chk("ie on keeps done", 0, out_done);
        out_xfer(16'h0005, 16'h0013, 1);
        chk("out irq", 1, out_irq);
        fn(1, FN_IE_OFF, 16'h0000);
        chk("irq off", 0, out_irq);
        chk("done readable", 1, out_done);
        fn(1, FN_CLEAR, 16'h0000);
        cyc(1);
        chk("cleared done", 0, out_done);
        slow = 1'b1;
        fn(1, FN_CTRL, 16'h0200);
        chk("control latch", 8'h02, co_ctrl);
        out_xfer(16'h0004, 16'h0040, 0);
        slow = 1'b0;
        fn(1, FN_CTRL, 16'hF900);
        d = (co_disc === 1'b1);
        repeat (3) @(negedge clk) d += (co_disc === 1'b1);
        chk("write disconnect", 1, d);
        chk("control latch 2", 8'hF9, co_ctrl);
        $display("test output done");
    endtask
    task automatic t_seq();
        fn(1, FN_CLEAR, 16'h0000);
        fn(1, FN_IE_ON, 16'h0000);
        @(negedge clk) kick = 1'b1;
        cyc(2);
        kick = 1'b0;
        cyc(6);
        maint = 4'h5;
        rd(1, FN_RD_STAT, 16'h800A, "out status");
        chk("seq busy", 0, out_busy);
        chk("seq irq", 1, out_irq);
        fn(1, FN_CLR_ERR, 16'h0000);
        rd(1, FN_RD_STAT, 16'h0005, "out status clr");
        chk("seq irq clr", 0, out_irq);
        $display("test sequence done");
    endtask
    task automatic t_in();
        fn(0, FN_IE_ON, 16'h0000);
        fn(0, FN_COUNT, 16'h0004);
        chk("count keeps busy", 0, in_busy);
        fn(0, FN_START, 16'h0022);
        for (int k = 0; k < 4; k++)
            send(16'h1230 + k, par(16'h1230 + k) ^ (k == 2 ? 4'h2 : 4'h0), 1'b0);
        wait_in();
        chk("store data", 64'h1233123212311230, wd_seen);
        chk("store addr", 16'h0020, a_seen);
        rd(0, FN_RD_ADDR, 16'h0024, "in address");
        rd(0, FN_RD_STAT, 16'h0002, "in status");
        chk("in irq", 1, in_irq);
        chk("in busy end", 0, in_busy);
        fn(0, FN_CLR_ERR, 16'h0000);
        rd(0, FN_RD_STAT, 16'h0000, "parity clr");
        chk("parity clr done", 1, in_done);
        fn(0, FN_IE_OFF, 16'h0000);
        chk("in irq off", 0, in_irq);
        chk("in done kept", 1, in_done);
        fn(0, FN_CLEAR, 16'h0000);
        cyc(1);
        chk("in cleared", 0, in_done);
        $display("test input done");
    endtask
    task automatic t_wait();
        send(16'h0F0F, 4'h0, 1'b0);
        rd(0, FN_RD_STAT, 16'h8000, "ready waiting");
        fn(0, FN_CTRL, 16'h0000);
        rd(0, FN_RD_STAT, 16'h0000, "waiting clr");
        send(16'h0F0F, 4'h0, 1'b0);
        ci_data = 16'h5A5A;
        ci_par  = par(16'h5A5A);
        fn(0, FN_COUNT, 16'h0001);
        fn(0, FN_START, 16'h0030);
        wait_in();
        chk("first parcel", 16'h5A5A, wd_seen[15:0]);
        rd(0, FN_RD_ADDR, 16'h0031, "one parcel addr");
        fn(0, FN_COUNT, 16'h0008);
        fn(0, FN_START, 16'h0050);
        send(16'h0777, par(16'h0777), 1'b0);
        send(16'h0000, 4'h0, 1'b1);
        wait_in();
        chk("disc busy", 0, in_busy);
        rd(0, FN_RD_ADDR, 16'h0051, "disc addr");
        $display("test ready waiting done");
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        chk("reset outputs", 0, {in_busy, in_done, in_irq, out_busy, out_done, out_irq,
            co_ready, co_disc, co_ctrl});
        t_out();
        t_seq();
        t_in();
        t_wait();
        summarize();
    end
endmodule
